// >>> event_source.sv
// External pulse source for an event pin: idles high, one falling edge per pulse.
module event_source (
	input  wire logic       clk,
	input  wire logic       start,
	input  wire logic [7:0] falls,
	input  wire logic [3:0] half,
	output logic            pin,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		pin  = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (start) begin
				busy <= 1'b1;
				// Each level stands half cycles; half of two is the fastest legal rate
				repeat (falls) begin
					pin <= 1'b0;
					repeat (half) @(posedge clk);
					pin <= 1'b1;
					repeat (half) @(posedge clk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule : event_source

// >>> event_sync.sv
// Two-stage synchroniser with rising and falling edge pulses.
module event_sync
	import timer_group_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic raw,
	output logic      rise,
	output logic      fall
);

	logic       meta;
	logic       level;
	logic       last;
	logic [2:0] filled;

	// ==========================================================================
	// Synchroniser; only the second stage is looked at
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta   <= 1'b0;
			level  <= 1'b0;
			last   <= 1'b0;
			filled <= 3'h0;
		end else begin
			meta   <= raw;
			level  <= meta;
			last   <= level;
			filled <= {filled[1:0], 1'b1};
		end
	end

	// Edges wait until every stage holds a real sample, so a pin idling high gives no false rise after reset
	wire ready = filled[2];

	assign rise = ready & level & ~last;
	assign fall = ready & ~level & last;

endmodule : event_sync

// >>> timer_group.sv
// Four counter/timers: two classic 13/16/8-bit units and two 16-bit auto-reload units, Wishbone slave.
//
// Notes on behaviour
// - Four independent 16-bit counter/timers exist, two classic and two auto-reload.
// - Timers zero and one count in 13-bit, 16-bit or 8-bit auto-reload mode, and timer zero alone may split into two 8-bit timers.
// - Timers two and three run as one 16-bit auto-reload timer or as two 8-bit timers each with its own reload.
// - Timers two and three can capture their count on an oscillator or comparator event to measure its period.
// - Timers zero and one choose from five clocks through a per-timer select bit and a shared two-bit prescale field.
// - Each of timers zero and one counts either the prescaled clock or the undivided system clock.
// - Timers two and three accept the system clock or the system clock divided by twelve.
// - Timer two may also count the real-time oscillator divided by eight or comparator zero.
// - Timer three may also count the external oscillator divided by eight or comparator one.
// - In counter operation timers zero and one increment on each falling edge of their event pin.
// - Event pins are counted correctly up to a quarter of the system clock rate.
// - The prescale field gives clock divided by 12, 4, 48, or the external clock divided by eight.
// - Timers zero and one run only with run set and either gating off or the gate input at its set polarity, except timer zero's split high byte.
// - A 13-bit wrap from all ones to zero sets the overflow flag, which serves as the interrupt request.
module timer_group
	import timer_group_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        timer_zero_event_pin,
	input  wire logic        timer_one_event_pin,
	input  wire logic        timer_zero_gate_input,
	input  wire logic        timer_one_gate_input,
	input  wire logic        ext_osc_clk,
	input  wire logic        rtc_osc_clk,
	input  wire logic        comparator0_out,
	input  wire logic        comparator1_out,
	output logic             timer_zero_overflow_flag,
	output logic             timer_one_overflow_flag
);

	// ==========================================================================
	// Helpers
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] offset);
		hit = (adr[7:2] == offset[7:2]);
	endfunction : hit

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
		input logic [3:0] sel);
		merge_bytes = old_val;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				merge_bytes[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
	endfunction : merge_bytes

	// ==========================================================================
	// Bus slave: one wait state, ack for one cycle, write commits at the acked edge
	logic        wr_go;
	logic [31:0] read_data;
	logic [15:0] ctrl;
	logic [6:0]  status;
	wire  [6:0]  status_set;

	assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
				wb_dat_o <= read_data;
			end
		end
	end

	wire wr_ctrl   = wr_go & hit(wb_adr_i, ADDR_CTRL);
	wire wr_status = wr_go & hit(wb_adr_i, ADDR_STATUS);
	wire [31:0] ctrl_merged = merge_bytes({16'h0000, ctrl}, wb_dat_i, wb_sel_i);
	wire [6:0]  status_clr  = (wr_status & wb_sel_i[0]) ? wb_dat_i[6:0] : 7'h00;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl   <= CTRL_RESET;
			status <= STATUS_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl <= ctrl_merged[15:0];
			end
			// A flag raised in the clearing cycle survives the clear
			status <= (status & ~status_clr) | status_set;
		end
	end

	assign timer_zero_overflow_flag = status[ST_T0_OVF];
	assign timer_one_overflow_flag  = status[ST_T1_OVF];

	// ==========================================================================
	// Input synchronisers
	wire [NUM_SYNC-1:0] raw_in = {comparator1_out, comparator0_out, rtc_osc_clk, ext_osc_clk,
		timer_one_event_pin, timer_zero_event_pin};
	logic [NUM_SYNC-1:0] in_rise;
	logic [NUM_SYNC-1:0] in_fall;

	genvar s;
	generate
		for (s = 0; s < NUM_SYNC; s++) begin : g_sync
			event_sync u_sync (
				.clk  (clk),
				.rst_n(rst_n),
				.raw  (raw_in[s]),
				.rise (in_rise[s]),
				.fall (in_fall[s])
			);
		end
	endgenerate

	// ==========================================================================
	// Clock dividers, all as one-cycle enables
	logic [3:0] div12_cnt;
	logic [1:0] div48_cnt;
	logic [2:0] ext_div_cnt;
	logic [2:0] rtc_div_cnt;

	wire div12_tick   = (div12_cnt == DIV12_LAST);
	wire div4_tick    = (div12_cnt[1:0] == DIV4_PHASE);
	wire div48_tick   = div12_tick & (div48_cnt == DIV48_LAST);
	wire ext_div8_tick = in_rise[IN_EXT_OSC] & (ext_div_cnt == OSC_DIV8_LAST);
	wire rtc_div8_tick = in_rise[IN_RTC_OSC] & (rtc_div_cnt == OSC_DIV8_LAST);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div12_cnt   <= 4'h0;
			div48_cnt   <= 2'h0;
			ext_div_cnt <= 3'h0;
			rtc_div_cnt <= 3'h0;
		end else begin
			div12_cnt <= div12_tick ? 4'h0 : div12_cnt + 4'h1;
			if (div12_tick) begin
				div48_cnt <= div48_cnt + 2'h1;
			end
			if (in_rise[IN_EXT_OSC]) begin
				ext_div_cnt <= ext_div_cnt + 3'h1;
			end
			if (in_rise[IN_RTC_OSC]) begin
				rtc_div_cnt <= rtc_div_cnt + 3'h1;
			end
		end
	end

	// Prescaled clock shared by timers zero and one
	prescale_t prescale_select;
	logic      prescale_tick;
	assign prescale_select = prescale_t'(ctrl[CTRL_PRESCALE_LSB +: 2]);
	assign prescale_tick = (prescale_select == PRESCALE_DIV12) ? div12_tick :
		(prescale_select == PRESCALE_DIV4) ? div4_tick :
		(prescale_select == PRESCALE_DIV48) ? div48_tick : ext_div8_tick;

	// ==========================================================================
	// Timers zero and one
	wire [1:0] gate_input = {timer_one_gate_input, timer_zero_gate_input};
	wire [1:0] pin_fall   = {in_fall[IN_T1_PIN], in_fall[IN_T0_PIN]};
	wire [1:0] timer_tick;
	logic [15:0] t01_count [2];

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_t01
			logic [7:0] lo;
			logic [7:0] hi;
			logic [7:0] next_lo;
			logic [7:0] next_hi;
			logic       ovf_set;
			logic       hi_ovf_set;
			logic       carry;
			basic_mode_t mode;

			assign mode = basic_mode_t'(ctrl[(i == 0 ? CTRL_MODE0_LSB : CTRL_MODE1_LSB) +: 2]);

			wire run_ok = ctrl[CTRL_RUN_LSB + i] & (~ctrl[CTRL_GATE_EN_LSB + i] |
				(gate_input[i] == ctrl[CTRL_GATE_POL_LSB + i]));
			assign timer_tick[i] = ctrl[CTRL_CLKSEL_LSB + i] ? 1'b1 : prescale_tick;
			wire step = run_ok & (ctrl[CTRL_COUNTER_LSB + i] ? pin_fall[i] : timer_tick[i]);
			// Split high byte of timer zero borrows timer one's run bit but uses timer zero's timer clock
			wire hi_step = (i == 0) ? (ctrl[CTRL_RUN_LSB + 1] & timer_tick[0]) : 1'b0;

			always_comb begin
				next_lo    = lo;
				next_hi    = hi;
				ovf_set    = 1'b0;
				hi_ovf_set = 1'b0;
				carry      = 1'b0;
				unique case (mode)
					MODE_13BIT: begin
						if (step) begin
							{carry, next_hi, next_lo[4:0]} = {1'b0, hi, lo[4:0]} + 14'h0001;
							ovf_set = carry;
						end
					end
					MODE_16BIT: begin
						if (step) begin
							{carry, next_hi, next_lo} = {1'b0, hi, lo} + 17'h00001;
							ovf_set = carry;
						end
					end
					MODE_8BIT_RELOAD: begin
						if (step) begin
							next_lo = (lo == 8'hff) ? hi : lo + 8'h01;
							ovf_set = (lo == 8'hff);
						end
					end
					MODE_SPLIT: begin
						// Timer one holds its count while set to split mode
						if (i == 0) begin
							if (step) begin
								{carry, next_lo} = {1'b0, lo} + 9'h001;
								ovf_set = carry;
							end
							if (hi_step) begin
								next_hi    = hi + 8'h01;
								hi_ovf_set = (hi == 8'hff);
							end
						end
					end
				endcase
			end

			wire        wr_count = wr_go & hit(wb_adr_i, ADDR_T01_COUNT[i]);
			wire [31:0] count_merged = merge_bytes({16'h0000, hi, lo}, wb_dat_i, wb_sel_i);

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					lo <= 8'h00;
					hi <= 8'h00;
				end else if (wr_count) begin
					lo <= count_merged[7:0];
					hi <= count_merged[15:8];
				end else begin
					lo <= next_lo;
					hi <= next_hi;
				end
			end

			assign status_set[ST_T0_OVF + i] = ovf_set;
			if (i == 0) begin : g_hi_flag
				assign status_set[ST_T0_HI_OVF] = hi_ovf_set;
			end
			assign t01_count[i] = {hi, lo};
		end
	endgenerate

	// ==========================================================================
	// Timers two and three
	wire [1:0] osc_tick = {ext_div8_tick, rtc_div8_tick};
	wire [1:0] cmp_rise = {in_rise[IN_CMP1], in_rise[IN_CMP0]};
	logic [6:0]  t23_ctrl   [2];
	logic [15:0] t23_count  [2];
	logic [15:0] t23_reload [2];

	genvar j;
	generate
		for (j = 0; j < 2; j++) begin : g_t23
			logic [6:0]  cfg;
			logic [15:0] cnt;
			logic [15:0] rel;
			logic [15:0] next_cnt;
			logic [15:0] next_rel;
			logic        lo_set;
			logic        hi_set;
			logic        carry;
			t23_source_t src;

			assign src = t23_source_t'(cfg[T23_SRC_LSB +: 2]);
			wire src_tick = (src == SRC_OSC_DIV8) ? osc_tick[j] :
				(src == SRC_COMPARATOR) ? cmp_rise[j] : div12_tick;
			wire capture_mode = cfg[T23_CAPTURE];
			// In capture the source picks the event, so counting uses the system clock or its /12
			wire capture_evt = (src == SRC_COMPARATOR) ? cmp_rise[j] : osc_tick[j];
			wire lo_tick = cfg[T23_LO_SYS] ? 1'b1 : (capture_mode ? div12_tick : src_tick);
			wire hi_tick = cfg[T23_HI_SYS] ? 1'b1 : src_tick;
			wire run     = cfg[T23_RUN];

			always_comb begin
				next_cnt = cnt;
				next_rel = rel;
				lo_set   = 1'b0;
				hi_set   = 1'b0;
				carry    = 1'b0;
				if (run && capture_mode) begin
					if (lo_tick) begin
						{carry, next_cnt} = {1'b0, cnt} + 17'h00001;
						lo_set = carry;
					end
					if (capture_evt) begin
						next_rel = cnt;
						hi_set   = 1'b1;
					end
				end else if (run && cfg[T23_SPLIT]) begin
					if (lo_tick) begin
						next_cnt[7:0] = (cnt[7:0] == 8'hff) ? rel[7:0] : cnt[7:0] + 8'h01;
						lo_set = (cnt[7:0] == 8'hff);
					end
					if (hi_tick) begin
						next_cnt[15:8] = (cnt[15:8] == 8'hff) ? rel[15:8] : cnt[15:8] + 8'h01;
						hi_set = (cnt[15:8] == 8'hff);
					end
				end else if (run && lo_tick) begin
					next_cnt = (cnt == 16'hffff) ? rel : cnt + 16'h0001;
					lo_set   = (cnt == 16'hffff);
				end
			end

			wire wr_cfg = wr_go & hit(wb_adr_i, ADDR_T23_CTRL[j]);
			wire wr_cnt = wr_go & hit(wb_adr_i, ADDR_T23_COUNT[j]);
			wire wr_rel = wr_go & hit(wb_adr_i, ADDR_T23_RELOAD[j]);
			wire [31:0] cfg_merged = merge_bytes({25'h0000000, cfg}, wb_dat_i, wb_sel_i);
			wire [31:0] cnt_merged = merge_bytes({16'h0000, cnt}, wb_dat_i, wb_sel_i);
			wire [31:0] rel_merged = merge_bytes({16'h0000, rel}, wb_dat_i, wb_sel_i);

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					cfg <= T23_CTRL_RESET;
					cnt <= 16'h0000;
					rel <= 16'h0000;
				end else begin
					cfg <= wr_cfg ? cfg_merged[6:0] : cfg;
					cnt <= wr_cnt ? cnt_merged[15:0] : next_cnt;
					rel <= wr_rel ? rel_merged[15:0] : next_rel;
				end
			end

			assign status_set[ST_T23_BASE + 2*j]     = lo_set;
			assign status_set[ST_T23_BASE + 2*j + 1] = hi_set;
			assign t23_ctrl[j]   = cfg;
			assign t23_count[j]  = cnt;
			assign t23_reload[j] = rel;
		end
	endgenerate

	// ==========================================================================
	// Read selection; unmapped addresses read zero and are still acknowledged
	wire [31:0] rd_ctrl   = hit(wb_adr_i, ADDR_CTRL) ? {16'h0000, ctrl} : 32'h0000_0000;
	wire [31:0] rd_status = hit(wb_adr_i, ADDR_STATUS) ? {25'h0000000, status} : 32'h0000_0000;
	wire [31:0] rd_t0 = hit(wb_adr_i, ADDR_T01_COUNT[0]) ? {16'h0000, t01_count[0]} : 32'h0000_0000;
	wire [31:0] rd_t1 = hit(wb_adr_i, ADDR_T01_COUNT[1]) ? {16'h0000, t01_count[1]} : 32'h0000_0000;
	wire [31:0] rd_t2c = hit(wb_adr_i, ADDR_T23_CTRL[0]) ? {25'h0000000, t23_ctrl[0]} : 32'h0000_0000;
	wire [31:0] rd_t3c = hit(wb_adr_i, ADDR_T23_CTRL[1]) ? {25'h0000000, t23_ctrl[1]} : 32'h0000_0000;
	wire [31:0] rd_t2n = hit(wb_adr_i, ADDR_T23_COUNT[0]) ? {16'h0000, t23_count[0]} : 32'h0000_0000;
	wire [31:0] rd_t3n = hit(wb_adr_i, ADDR_T23_COUNT[1]) ? {16'h0000, t23_count[1]} : 32'h0000_0000;
	wire [31:0] rd_t2r = hit(wb_adr_i, ADDR_T23_RELOAD[0]) ? {16'h0000, t23_reload[0]} : 32'h0000_0000;
	wire [31:0] rd_t3r = hit(wb_adr_i, ADDR_T23_RELOAD[1]) ? {16'h0000, t23_reload[1]} : 32'h0000_0000;

	assign read_data = rd_ctrl | rd_status | rd_t0 | rd_t1 | rd_t2c | rd_t3c | rd_t2n | rd_t3n
		| rd_t2r | rd_t3r;

endmodule : timer_group

// >>> timer_group_asserts.sv
// Concurrent checks on the timer group's bus handshake and overflow flag ports.
module timer_group_asserts
	import timer_group_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        timer_zero_gate_input,
	input wire logic        timer_one_gate_input,
	input wire logic        timer_zero_overflow_flag,
	input wire logic        timer_one_overflow_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ========================================
	// Shadow of the control register, taken from acknowledged writes
	logic [15:0] ctrl_sh;
	logic [1:0]  idle0;
	logic [1:0]  idle1;
	wire         wr_ack   = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;
	wire         ctrl_wr  = wr_ack & (wb_adr_i[7:2] == ADDR_CTRL[7:2]);
	wire         st_wr    = wr_ack & (wb_adr_i[7:2] == ADDR_STATUS[7:2]) & wb_sel_i[0];
	wire         clr0     = st_wr & wb_dat_i[ST_T0_OVF];
	wire         clr1     = st_wr & wb_dat_i[ST_T1_OVF];
	wire         unmapped = wb_adr_i[7:2] > 6'h09;
	wire [1:0]   gate_in  = {timer_one_gate_input, timer_zero_gate_input};
	wire [1:0]   gate_ok  = ~ctrl_sh[CTRL_GATE_EN_LSB +: 2] | ~(gate_in ^ ctrl_sh[CTRL_GATE_POL_LSB +: 2]);
	wire [1:0]   run_en   = ctrl_sh[CTRL_RUN_LSB +: 2] & gate_ok;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_sh <= CTRL_RESET;
			idle0   <= 2'h0;
			idle1   <= 2'h0;
		end else begin
			if (ctrl_wr && wb_sel_i[0]) ctrl_sh[7:0] <= wb_dat_i[7:0];
			if (ctrl_wr && wb_sel_i[1]) ctrl_sh[15:8] <= wb_dat_i[15:8];
			// Saturates at three so a pipelined flag update still falls inside the window
			idle0 <= run_en[0] ? 2'h0 : idle0 + {1'b0, idle0 != 2'h3};
			idle1 <= run_en[1] ? 2'h0 : idle1 + {1'b0, idle1 != 2'h3};
		end
	end

	// ========================================
	// Assertions
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged in the next cycle");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge held longer than one cycle");
	AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("acknowledge without a request");
	AST_UNMAPPED_ZERO: assert property (wb_ack_o && !wb_we_i && unmapped |-> wb_dat_o == 32'h0)
		else $error("unmapped read returned nonzero data");
	AST_T0_IDLE_NO_OVF: assert property (idle0 == 2'h3 |-> !$rose(timer_zero_overflow_flag))
		else $error("timer zero overflowed while stopped or gated");
	AST_T1_IDLE_NO_OVF: assert property (idle1 == 2'h3 |-> !$rose(timer_one_overflow_flag))
		else $error("timer one overflowed while stopped or gated");
	AST_T0_CLEAR: assert property (clr0 && idle0 == 2'h3 |=> !timer_zero_overflow_flag)
		else $error("timer zero flag not cleared by write one");
	AST_T0_FLAG_HOLD: assert property (timer_zero_overflow_flag && !clr0 |=> timer_zero_overflow_flag)
		else $error("timer zero flag dropped without a clear");
	AST_T1_FLAG_HOLD: assert property (timer_one_overflow_flag && !clr1 |=> timer_one_overflow_flag)
		else $error("timer one flag dropped without a clear");
endmodule : timer_group_asserts

bind timer_group timer_group_asserts checker_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_zero_gate_input(timer_zero_gate_input),
	.timer_one_gate_input(timer_one_gate_input), .timer_zero_overflow_flag(timer_zero_overflow_flag),
	.timer_one_overflow_flag(timer_one_overflow_flag));

// >>> timer_group_pkg.sv
// Shared constants for the four-timer group: register map, fields, modes and dividers.
package timer_group_pkg;

	// ==========================================================================
	// Register map (byte addresses on the 32-bit bus)
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_T01_COUNT [2] = '{8'h08, 8'h0c};
	localparam logic [7:0] ADDR_T23_CTRL  [2] = '{8'h10, 8'h1c};
	localparam logic [7:0] ADDR_T23_COUNT [2] = '{8'h14, 8'h20};
	localparam logic [7:0] ADDR_T23_RELOAD[2] = '{8'h18, 8'h24};

	// ==========================================================================
	// Shared control register fields (two-bit groups: bit 0 timer zero, bit 1 timer one, except the per-timer mode fields and shared prescale)
	localparam int CTRL_RUN_LSB      = 0;
	localparam int CTRL_GATE_EN_LSB  = 2;
	localparam int CTRL_GATE_POL_LSB = 4;
	localparam int CTRL_COUNTER_LSB  = 6;
	localparam int CTRL_MODE0_LSB    = 8;
	localparam int CTRL_MODE1_LSB    = 10;
	localparam int CTRL_CLKSEL_LSB   = 12;
	localparam int CTRL_PRESCALE_LSB = 14;
	localparam int CTRL_WIDTH        = 16;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// Timer two/three control fields
	localparam int T23_RUN       = 0;
	localparam int T23_SPLIT     = 1;
	localparam int T23_CAPTURE   = 2;
	localparam int T23_SRC_LSB   = 3;
	localparam int T23_LO_SYS    = 5;
	localparam int T23_HI_SYS    = 6;
	localparam int T23_CTRL_W    = 7;
	localparam logic [6:0] T23_CTRL_RESET = 7'h00;

	// Status flags, write one to clear
	localparam int ST_T0_OVF    = 0;
	localparam int ST_T1_OVF    = 1;
	localparam int ST_T0_HI_OVF = 2;
	localparam int ST_T23_BASE  = 3;
	localparam int STATUS_W     = 7;
	localparam logic [6:0] STATUS_RESET = 7'h00;

	// ==========================================================================
	// Modes and sources
	typedef enum logic [1:0] {
		MODE_13BIT       = 2'b00,
		MODE_16BIT       = 2'b01,
		MODE_8BIT_RELOAD = 2'b10,
		MODE_SPLIT       = 2'b11
	} basic_mode_t;

	typedef enum logic [1:0] {
		PRESCALE_DIV12    = 2'b00,
		PRESCALE_DIV4     = 2'b01,
		PRESCALE_DIV48    = 2'b10,
		PRESCALE_EXT_DIV8 = 2'b11
	} prescale_t;

	typedef enum logic [1:0] {
		SRC_SYS_DIV12  = 2'b00,
		SRC_OSC_DIV8   = 2'b01,
		SRC_COMPARATOR = 2'b10,
		SRC_SPARE      = 2'b11
	} t23_source_t;

	// ==========================================================================
	// Dividers
	localparam logic [3:0] DIV12_LAST    = 4'hb;
	localparam logic [1:0] DIV4_PHASE    = 2'h3;
	localparam logic [1:0] DIV48_LAST    = 2'h3;
	localparam logic [2:0] OSC_DIV8_LAST = 3'h7;

	// Synchronised input slots
	localparam int IN_T0_PIN  = 0;
	localparam int IN_T1_PIN  = 1;
	localparam int IN_EXT_OSC = 2;
	localparam int IN_RTC_OSC = 3;
	localparam int IN_CMP0    = 4;
	localparam int IN_CMP1    = 5;
	localparam int NUM_SYNC   = 6;

endpackage : timer_group_pkg

// >>> timer_group_tb.sv
// Self-checking testbench for the four-timer group.
module timer_group_tb
	import timer_group_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic [15:0] ctrl;
		logic [15:0] preset;
		int          span;
		logic [15:0] count;
		logic        flag;
	} row_t;

	logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [1:0]  gate;
	wire  [1:0]  flags;
	logic [2:0]  st;
	wire  [2:0]  ev, bz;
	logic [7:0]  nf [3];
	logic [3:0]  hf [3];
	int          tick = 0;
	int          t_ack, ta, fail_count, n_tests;
	// Spans are multiples of the clock period each row selects, so the count does not depend on phase
	row_t        rows [6] = '{
		'{16'h353f, 16'h0000, 96, 16'h0060, 1'b0}, '{16'h053f, 16'h0000, 96, 16'h0008, 1'b0},
		'{16'h453f, 16'h0000, 96, 16'h0018, 1'b0}, '{16'h853f, 16'h0000, 96, 16'h0002, 1'b0},
		'{16'h3a3f, 16'hf0f0, 100, 16'hf0f4, 1'b1}, '{16'h353f, 16'hfff0, 20, 16'h0004, 1'b1}};

	timer_group dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.timer_zero_event_pin(ev[0]), .timer_one_event_pin(ev[1]), .timer_zero_gate_input(gate[0]),
		.timer_one_gate_input(gate[1]), .ext_osc_clk(ev[2]), .rtc_osc_clk(ev[2]), .comparator0_out(ev[2]),
		.comparator1_out(ev[2]), .timer_zero_overflow_flag(flags[0]), .timer_one_overflow_flag(flags[1]));

	for (genvar i = 0; i < 3; i++) begin : g_src
		event_source src (.clk(clk), .start(st[i]), .falls(nf[i]), .half(hf[i]), .pin(ev[i]), .busy(bz[i]));
	end

	// ========================================
	// Tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hf;
		wb_dat_i <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) fail_count++;
		rd = wb_dat_o;
		t_ack = tick;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : xfer

	task automatic window(input int span);
		@(posedge clk);
		gate <= 2'b11;
		repeat (span) @(posedge clk);
		gate <= 2'b00;
	endtask : window

	task automatic pulse(input int i, input logic [7:0] f, input logic [3:0] h);
		int n;
		n = 0;
		@(posedge clk);
		nf[i] <= f;
		hf[i] <= h;
		st[i] <= 1'b1;
		@(posedge clk);
		st[i] <= 1'b0;
		@(posedge clk);
		while (bz[i] === 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
	endtask : pulse

	task automatic counts(input logic [15:0] preset);
		for (int i = 0; i < 2; i++) xfer(1'b1, ADDR_T01_COUNT[i], {16'h0, preset});
	endtask : counts

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	// ========================================
	// Clock, watchdog and sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) tick <= tick + 1;

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run();
	end

	initial begin
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, gate, st} = '0;
		nf = '{default: 8'h0};
		hf = '{default: 4'h2};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[r]) begin
			xfer(1'b1, ADDR_CTRL, {16'h0, rows[r].ctrl});
			counts(rows[r].preset);
			xfer(1'b1, ADDR_STATUS, 32'h3);
			window(rows[r].span);
			for (int i = 0; i < 2; i++) begin
				xfer(1'b0, ADDR_T01_COUNT[i], 32'h0);
				check("timer count", rd, {16'h0, rows[r].count});
				check("overflow flag", {31'h0, flags[i]}, {31'h0, rows[r].flag});
			end
		end
		// 13-bit wrap: upper three bits of the low byte hold their value
		xfer(1'b1, ADDR_CTRL, 32'h303f);
		counts(16'hffbd);
		xfer(1'b1, ADDR_STATUS, 32'h3);
		window(2);
		xfer(1'b0, ADDR_T01_COUNT[0], 32'h0);
		check("13-bit count", rd, 32'hffbf);
		check("flag before wrap", {31'h0, flags[0]}, 32'h0);
		window(1);
		xfer(1'b0, ADDR_T01_COUNT[0], 32'h0);
		check("13-bit wrap", rd, 32'h00a0);
		check("flag after wrap", {30'h0, flags}, 32'h3);
		xfer(1'b1, ADDR_STATUS, 32'h1);
		@(posedge clk);
		check("flags after clear", {30'h0, flags}, 32'h2);
		// Pin falls at the fastest legal rate and at a slower one
		xfer(1'b1, ADDR_CTRL, 32'h05c3);
		counts(16'h0);
		pulse(0, 8'd20, 4'd2);
		pulse(1, 8'd9, 4'd3);
		repeat (6) @(posedge clk);
		for (int i = 0; i < 2; i++) begin
			xfer(1'b0, ADDR_T01_COUNT[i], 32'h0);
			check("pin event count", rd, i ? 32'd9 : 32'd20);
		end
		// Sixteen external clock rises give two prescaled ticks
		xfer(1'b1, ADDR_CTRL, 32'hc53f);
		for (int i = 0; i < 2; i++) xfer(1'b1, ADDR_T23_CTRL[i], 32'h9);
		counts(16'h0);
		@(posedge clk);
		gate <= 2'b11;
		pulse(2, 8'd16, 4'd2);
		repeat (6) @(posedge clk);
		gate <= 2'b00;
		for (int i = 0; i < 2; i++) begin
			xfer(1'b0, ADDR_T01_COUNT[i], 32'h0);
			check("external prescale count", rd, 32'd2);
			xfer(1'b0, ADDR_T23_COUNT[i], 32'h0);
			check("oscillator count", rd, 32'h2);
		end
		// Auto-reload timers on the system clock; ticks are the edges between the two writes
		for (int i = 0; i < 2; i++) begin
			xfer(1'b1, ADDR_T23_RELOAD[i], 32'hfff0);
			xfer(1'b1, ADDR_T23_COUNT[i], 32'hfff0);
			xfer(1'b1, ADDR_T23_CTRL[i], 32'h21);
			ta = t_ack;
			repeat (40) @(posedge clk);
			xfer(1'b1, ADDR_T23_CTRL[i], 32'h0);
			ta = t_ack - ta;
			xfer(1'b0, ADDR_T23_COUNT[i], 32'h0);
			check("reload count", rd, {16'h0, 16'hfff0 + 16'(ta % 16)});
			xfer(1'b0, ADDR_STATUS, 32'h0);
			check("reload flag", {31'h0, rd[ST_T23_BASE + 2 * i]}, 32'h1);
		end
		// Capture on comparator rises: two captures lie as many counts apart as cycles between the events
		xfer(1'b1, ADDR_T23_CTRL[0], 32'h35);
		ta = t_ack;
		pulse(2, 8'h1, 4'h2);
		xfer(1'b0, ADDR_T23_RELOAD[0], 32'h0);
		ta = int'(rd) + t_ack - ta;
		pulse(2, 8'h1, 4'h2);
		xfer(1'b0, ADDR_T23_RELOAD[0], 32'h0);
		check("capture period", rd, {16'h0, 16'(ta)});
		xfer(1'b0, ADDR_STATUS, 32'h0);
		check("capture flag", {31'h0, rd[ST_T23_BASE + 1]}, 32'h1);
		// Second reset: every register reads zero, unmapped places too
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		check("flags after reset", {30'h0, flags}, 32'h0);
		xfer(1'b1, 8'h3c, 32'hffffffff);
		for (int a = 0; a < 16; a++) begin
			xfer(1'b0, 8'(a * 4), 32'h0);
			check("reset or unmapped read", rd, 32'h0);
		end
		complete_run();
	end
endmodule : timer_group_tb
